/* boot_strap_pkg.sv */
package boot_strap_pkg;

	// Boot sources after decoding
	typedef enum logic [3:0] {
		BOOT_NONE,
		BOOT_NAND8,
		BOOT_NAND16,
		BOOT_SERIAL_DL,
		BOOT_EEPROM,
		BOOT_INT_UNDEF,
		BOOT_ASYNC_ROM,
		BOOT_ASYNC_INVALID,
		BOOT_SYNC_FLASH,
		BOOT_SYNC_ROM
	} boot_src_t;

	// Width strap codes
	localparam logic [1:0] WIDTH_CODE_A = 2'h0;
	localparam logic [1:0] WIDTH_CODE_B = 2'h1;
	localparam logic [1:0] WIDTH_CODE_C = 2'h2;
	localparam logic [1:0] WIDTH_CODE_D = 2'h3;

	// Address byte counts for NAND boot
	localparam logic [2:0] NAND_ADDR_3 = 3'h3;
	localparam logic [2:0] NAND_ADDR_4 = 3'h4;
	localparam logic [2:0] NAND_ADDR_5 = 3'h5;

	// Data path width codes: 0 = 8, 1 = 16, 2 = 32 bit
	localparam logic [1:0] BUS_8 = 2'h0;
	localparam logic [1:0] BUS_16 = 2'h1;
	localparam logic [1:0] BUS_32 = 2'h2;

	// Bank numbers mapped at address zero
	localparam logic [2:0] BANK_SYNC_BOOT = 3'h4;
	localparam logic [2:0] BANK_ASYNC_BOOT = 3'h0;

	// Memory configuration sequence length in cycles
	localparam logic [7:0] CFG_SEQ_CYCLES = 8'h10;

	// Reset values
	localparam logic [4:0] STRAP_RESET = 5'h00;

endpackage

/* strap_sync.sv */
module strap_sync #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Asynchronous level in, synchronised level out
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	// Two-stage synchroniser state
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t state;
	sync_state_t next_state;

	// Shift through two stages
	always_comb begin
		next_state.meta = i_async;
		next_state.stable = state.meta;
	end

	// Register the stages
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_sync = state.stable;

endmodule

/* cfg_seq_timer.sv */
module cfg_seq_timer #(
	parameter int CYCLES = 16
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// One-cycle start pulse, busy level, one-cycle done pulse
	input wire logic i_start,
	output logic o_busy,
	output logic o_done
);

	// Counter state
	typedef struct packed {
		logic busy;
		logic done;
		logic [15:0] count;
	} timer_state_t;

	timer_state_t state;
	timer_state_t next_state;

	// Count down the configuration sequence
	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		if (i_start && !state.busy) begin
			// Load the length
			next_state.busy = 1'b1;
			next_state.count = 16'(CYCLES - 1);
		end else if (state.busy) begin
			if (state.count == 16'h0000) begin
				// Sequence finished
				next_state.busy = 1'b0;
				next_state.done = 1'b1;
			end else begin
				next_state.count = state.count - 16'h0001;
			end
		end
	end

	// Register the counter
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_busy = state.busy;
	assign o_done = state.done;

endmodule

/* boot_mode_strap_decoder.sv */
module boot_mode_strap_decoder #(
	parameter int CFG_CYCLES = int'(boot_strap_pkg::CFG_SEQ_CYCLES),
	parameter bit SYNC_FLASH_CFG = 1'b1
) (
	// Clock and power-on reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Strap pins from the board
	input wire logic i_port_a_bit_seven_strap,
	input wire logic i_media_change_strap,
	input wire logic i_width_strap_high,
	input wire logic i_width_strap_low,
	input wire logic i_internal_boot_strap,
	// Latched strap values
	output logic [4:0] o_straps_latched,
	output logic o_straps_valid,
	// Decoded boot mode
	output boot_strap_pkg::boot_src_t o_boot_src,
	output logic o_boot_internal,
	output logic o_boot_undefined,
	output logic o_boot_invalid,
	output logic [2:0] o_nand_addr_bytes,
	output logic [1:0] o_bus_width,
	output logic o_init_mode_register,
	// Address zero mapping
	output logic [2:0] o_boot_bank,
	output logic o_map_sync_chip_select_three,
	output logic o_map_bank_zero_chip_select,
	// Configuration sequence and processor release
	output logic o_cfg_seq_busy,
	output logic o_cpu_release
);

	// Controller phases; five states leave three codes unused
	typedef enum logic [2:0] {
		ST_SETTLE,
		ST_FILL,
		ST_CAPTURE,
		ST_CONFIG,
		ST_RUN
	} phase_t;

	// All state of this module except the reset synchroniser flops
	typedef struct packed {
		phase_t phase;
		logic [4:0] straps;
		logic valid;
		boot_strap_pkg::boot_src_t src;
		logic internal;
		logic undefined;
		logic invalid;
		logic [2:0] addr_bytes;
		logic [1:0] bus_width;
		logic init_mode;
		logic [2:0] bank;
		logic map_sync;
		logic map_async;
		logic cfg_start;
		logic release_cpu;
	} dec_state_t;

	// Reset release synchroniser
	logic rst_meta;
	logic rst_sync_n;

	// Synchronised strap pins
	logic [4:0] strap_raw;
	logic [4:0] strap_sync;

	// Configuration sequence handshake
	logic cfg_busy;
	logic cfg_done;

	dec_state_t state;
	dec_state_t next_state;

	// Decode scratch values
	boot_strap_pkg::boot_src_t dec_src;
	logic [2:0] dec_bytes;
	logic [1:0] dec_width;
	logic [1:0] wcode;
	logic port_bit;
	logic media_bit;
	logic int_bit;

	// Release reset through two flops, assert asynchronously
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Strap bit order: port, media, width high, width low, internal
	assign strap_raw = {i_port_a_bit_seven_strap, i_media_change_strap,
		i_width_strap_high, i_width_strap_low, i_internal_boot_strap};

	// Pins pass two flops before use
	strap_sync #(
		.WIDTH(5)
	) u_strap_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_sync_n),
		.i_async(strap_raw),
		.o_sync(strap_sync)
	);

	// Timer for the memory configuration sequence
	cfg_seq_timer #(
		.CYCLES(CFG_CYCLES)
	) u_cfg_seq_timer (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_sync_n),
		.i_start(state.cfg_start),
		.o_busy(cfg_busy),
		.o_done(cfg_done)
	);

	// Field views of the latched straps
	// Decode reads only the latched copy, so later pin
	// activity cannot disturb the boot mode
	assign port_bit = state.straps[4];
	assign media_bit = state.straps[3];
	assign wcode = state.straps[2:1];
	assign int_bit = state.straps[0];

	// Decode latched straps into a boot source
	always_comb begin
		dec_src = boot_strap_pkg::BOOT_INT_UNDEF;
		dec_bytes = boot_strap_pkg::NAND_ADDR_3;
		dec_width = boot_strap_pkg::BUS_8;
		// Address byte count from width straps
		unique case (wcode)
			boot_strap_pkg::WIDTH_CODE_A: dec_bytes = boot_strap_pkg::NAND_ADDR_3;
			boot_strap_pkg::WIDTH_CODE_B: dec_bytes = boot_strap_pkg::NAND_ADDR_4;
			boot_strap_pkg::WIDTH_CODE_C: dec_bytes = boot_strap_pkg::NAND_ADDR_5;
			boot_strap_pkg::WIDTH_CODE_D: dec_bytes = boot_strap_pkg::NAND_ADDR_3;
		endcase
		if (int_bit) begin
			// Internal boot ROM variants
			if (!media_bit && wcode != boot_strap_pkg::WIDTH_CODE_D) begin
				// NAND over 8 or 16 bits
				dec_src = port_bit ? boot_strap_pkg::BOOT_NAND16 :
					boot_strap_pkg::BOOT_NAND8;
				dec_width = port_bit ? boot_strap_pkg::BUS_16 :
					boot_strap_pkg::BUS_8;
			end else if (media_bit && !port_bit &&
				wcode == boot_strap_pkg::WIDTH_CODE_A) begin
				dec_src = boot_strap_pkg::BOOT_SERIAL_DL;
			end else if (media_bit && !port_bit &&
				wcode == boot_strap_pkg::WIDTH_CODE_B) begin
				dec_src = boot_strap_pkg::BOOT_EEPROM;
			end else begin
				dec_src = boot_strap_pkg::BOOT_INT_UNDEF;
			end
		end else if (!media_bit) begin
			// External asynchronous ROM
			unique case (wcode)
				boot_strap_pkg::WIDTH_CODE_A: dec_width = boot_strap_pkg::BUS_8;
				boot_strap_pkg::WIDTH_CODE_B: dec_width = boot_strap_pkg::BUS_16;
				boot_strap_pkg::WIDTH_CODE_C: dec_width = boot_strap_pkg::BUS_32;
				boot_strap_pkg::WIDTH_CODE_D: dec_width = boot_strap_pkg::BUS_8;
			endcase
			// Width 11 is flagged; board must not strap it
			dec_src = (wcode == boot_strap_pkg::WIDTH_CODE_D) ?
				boot_strap_pkg::BOOT_ASYNC_INVALID :
				boot_strap_pkg::BOOT_ASYNC_ROM;
		end else begin
			// External synchronous flash or ROM
			dec_width = wcode[1] ? boot_strap_pkg::BUS_32 :
				boot_strap_pkg::BUS_16;
			dec_src = wcode[0] ? boot_strap_pkg::BOOT_SYNC_ROM :
				boot_strap_pkg::BOOT_SYNC_FLASH;
		end
	end

	// Boot sequencing: settle, fill, capture, configure, run
	always_comb begin
		next_state = state;
		next_state.cfg_start = 1'b0;
		unique case (state.phase)
			ST_SETTLE: begin
				// First stage takes the pins on this edge
				next_state.phase = ST_FILL;
			end
			ST_FILL: begin
				// Second stage fills; the synchroniser leaves
				// reset with the internal reset, so capturing
				// any earlier would latch its zero reset value
				next_state.phase = ST_CAPTURE;
			end
			ST_CAPTURE: begin
				// Capture the five straps once
				next_state.straps = strap_sync;
				next_state.valid = 1'b1;
				next_state.phase = ST_CONFIG;
			end
			ST_CONFIG: begin
				if (!state.valid || state.src == boot_strap_pkg::BOOT_NONE) begin
					// First config cycle: record the decode
					next_state.src = dec_src;
					next_state.internal = int_bit;
					next_state.undefined =
						(dec_src == boot_strap_pkg::BOOT_INT_UNDEF);
					next_state.invalid =
						(dec_src == boot_strap_pkg::BOOT_ASYNC_INVALID);
					next_state.addr_bytes = dec_bytes;
					next_state.bus_width = dec_width;
					next_state.init_mode = !int_bit && media_bit;
					next_state.map_sync = !int_bit && media_bit;
					next_state.map_async = !int_bit && !media_bit;
					next_state.bank = (!int_bit && media_bit) ?
						boot_strap_pkg::BANK_SYNC_BOOT :
						boot_strap_pkg::BANK_ASYNC_BOOT;
					// Sync ROM always, sync flash when enabled
					if (dec_src == boot_strap_pkg::BOOT_SYNC_ROM ||
						(dec_src == boot_strap_pkg::BOOT_SYNC_FLASH &&
						SYNC_FLASH_CFG)) begin
						next_state.cfg_start = 1'b1;
					end else begin
						next_state.phase = ST_RUN;
						next_state.release_cpu = 1'b1;
					end
				end else if (cfg_done) begin
					// Sequence complete, release processor
					next_state.phase = ST_RUN;
					next_state.release_cpu = 1'b1;
				end
			end
			ST_RUN: begin
				// Hold everything until next power-on reset
				next_state = state;
			end
			default: begin
				// Unused phase code: restart the boot sequence
				next_state.phase = ST_SETTLE;
			end
		endcase
	end

	// Register all state except the reset synchroniser flops
	// Reset values are constants only
	always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state.phase <= ST_SETTLE;
			state.straps <= boot_strap_pkg::STRAP_RESET;
			state.valid <= 1'b0;
			state.src <= boot_strap_pkg::BOOT_NONE;
			state.internal <= 1'b0;
			state.undefined <= 1'b0;
			state.invalid <= 1'b0;
			state.addr_bytes <= boot_strap_pkg::NAND_ADDR_3;
			state.bus_width <= boot_strap_pkg::BUS_8;
			state.init_mode <= 1'b0;
			state.bank <= boot_strap_pkg::BANK_ASYNC_BOOT;
			state.map_sync <= 1'b0;
			state.map_async <= 1'b0;
			state.cfg_start <= 1'b0;
			state.release_cpu <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from state
	assign o_straps_latched = state.straps;
	assign o_straps_valid = state.valid;
	assign o_boot_src = state.src;
	assign o_boot_internal = state.internal;
	assign o_boot_undefined = state.undefined;
	assign o_boot_invalid = state.invalid;
	assign o_nand_addr_bytes = state.addr_bytes;
	assign o_bus_width = state.bus_width;
	assign o_init_mode_register = state.init_mode;
	assign o_boot_bank = state.bank;
	assign o_map_sync_chip_select_three = state.map_sync;
	assign o_map_bank_zero_chip_select = state.map_async;
	assign o_cfg_seq_busy = cfg_busy;
	assign o_cpu_release = state.release_cpu;

endmodule

/* boot_decoder_props.sv */
module boot_decoder_props #(
	parameter int CFG_CYCLES = 16
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Watched outputs
	input wire logic [4:0] o_straps_latched,
	input wire boot_strap_pkg::boot_src_t o_boot_src,
	input wire logic o_boot_internal,
	input wire logic o_boot_undefined,
	input wire logic [2:0] o_nand_addr_bytes,
	input wire logic [1:0] o_bus_width,
	input wire logic o_init_mode_register,
	input wire logic [2:0] o_boot_bank,
	input wire logic o_map_sync_chip_select_three,
	input wire logic o_map_bank_zero_chip_select,
	input wire logic o_cfg_seq_busy,
	input wire logic o_cpu_release
);
	// Length of the current busy run
	logic [15:0] busy_len;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	// Counts busy cycles, clears when idle
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_len <= 16'h0000;
		end else if (o_cfg_seq_busy) begin
			busy_len <= busy_len + 16'h0001;
		end else begin
			busy_len <= 16'h0000;
		end
	end
	a_sync_bank_map: assert property (
		o_init_mode_register |-> o_boot_bank == 3'h4
		&& o_map_sync_chip_select_three)
		else $error("Sync boot bank not at zero");
	a_async_rom_map: assert property (
		o_boot_src == boot_strap_pkg::BOOT_ASYNC_ROM |->
		o_bus_width == o_straps_latched[2:1] && o_boot_bank == 3'h0
		&& o_map_bank_zero_chip_select)
		else $error("Async boot width or bank wrong");
	a_sync_width_sel: assert property (
		o_init_mode_register |-> o_straps_latched[3]
		&& !o_straps_latched[0]
		&& o_bus_width == (o_straps_latched[2] ? 2'h2 : 2'h1))
		else $error("Sync boot width or straps wrong");
	a_nand_addr_bytes: assert property (
		o_boot_src inside {boot_strap_pkg::BOOT_NAND8,
		boot_strap_pkg::BOOT_NAND16} |->
		o_nand_addr_bytes == 3'h3 + {1'b0, o_straps_latched[2:1]})
		else $error("NAND address byte count wrong");
	a_nand_wide_port: assert property (
		o_boot_src == boot_strap_pkg::BOOT_NAND16 |->
		o_straps_latched[4] && o_bus_width == 2'h1)
		else $error("Wide NAND without port strap");
	a_mode_held: assert property (
		o_cpu_release && $past(o_cpu_release) |->
		$stable(o_straps_latched) && $stable(o_boot_src))
		else $error("Boot mode changed after decode");
	a_internal_flag: assert property (
		o_cpu_release |-> o_boot_internal == o_straps_latched[0])
		else $error("Internal flag differs from strap");
	a_undef_flag: assert property (
		o_cpu_release |-> o_boot_undefined
		== (o_boot_src == boot_strap_pkg::BOOT_INT_UNDEF))
		else $error("Undefined flag wrong");
	a_busy_holds_cpu: assert property (
		o_cfg_seq_busy |-> !o_cpu_release ##1 !o_cpu_release)
		else $error("Processor released during sequence");
	a_busy_length: assert property (
		$fell(o_cfg_seq_busy) |-> busy_len == CFG_CYCLES)
		else $error("Config sequence length wrong");
	// Main scenarios
	c_sync: cover property ($fell(o_cfg_seq_busy));
	c_async: cover property (o_map_bank_zero_chip_select);
	c_wide: cover property (o_boot_src == boot_strap_pkg::BOOT_NAND16);
endmodule
bind boot_mode_strap_decoder boot_decoder_props #(
	.CFG_CYCLES(CFG_CYCLES)
) props (.i_clk_sys, .i_rst_n, .o_straps_latched, .o_boot_src,
	.o_boot_internal, .o_boot_undefined, .o_nand_addr_bytes,
	.o_bus_width, .o_init_mode_register, .o_boot_bank,
	.o_map_sync_chip_select_three, .o_map_bank_zero_chip_select,
	.o_cfg_seq_busy, .o_cpu_release);

/* board_strap_model.sv */
module board_strap_model (
	// Pattern {port, media, width high, width low, internal}
	input wire logic [4:0] i_pattern,
	// Strap pins
	output logic o_port,
	output logic o_media,
	output logic o_whigh,
	output logic o_wlow,
	output logic o_internal
);
	timeunit 1ns;
	timeprecision 1ps;
	// Board levels, static per wiring
	always_comb begin
		{o_port, o_media, o_whigh, o_wlow, o_internal} = i_pattern;
	end
endmodule

/* tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] pattern = 5'h00;
	logic s_p, s_m, s_h, s_l, s_i;
	logic [4:0] latched;
	boot_strap_pkg::boot_src_t src;
	logic valid, intb, undef, inval, init, map3, map0, busy, rel;
	logic [2:0] nbytes, bank;
	logic [1:0] bw;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	board_strap_model board (.i_pattern(pattern), .o_port(s_p),
		.o_media(s_m), .o_whigh(s_h), .o_wlow(s_l), .o_internal(s_i));
	boot_mode_strap_decoder #(.CFG_CYCLES(4)) dut (.i_clk_sys(clk),
		.i_rst_n(rst_n), .i_port_a_bit_seven_strap(s_p),
		.i_media_change_strap(s_m), .i_width_strap_high(s_h),
		.i_width_strap_low(s_l), .i_internal_boot_strap(s_i),
		.o_straps_latched(latched), .o_straps_valid(valid),
		.o_boot_src(src), .o_boot_internal(intb),
		.o_boot_undefined(undef), .o_boot_invalid(inval),
		.o_nand_addr_bytes(nbytes), .o_bus_width(bw),
		.o_init_mode_register(init), .o_boot_bank(bank),
		.o_map_sync_chip_select_three(map3),
		.o_map_bank_zero_chip_select(map0),
		.o_cfg_seq_busy(busy), .o_cpu_release(rel));
	// Clock
	initial begin
		forever #10 clk = ~clk;
	end
	// Expected boot source for a pattern
	function automatic boot_strap_pkg::boot_src_t ex(input logic [4:0] c);
		if (!c[0]) begin
			if (c[3]) begin
				return c[1] ? boot_strap_pkg::BOOT_SYNC_ROM
					: boot_strap_pkg::BOOT_SYNC_FLASH;
			end
			return (c[2:1] == 2'h3) ? boot_strap_pkg::BOOT_ASYNC_INVALID
				: boot_strap_pkg::BOOT_ASYNC_ROM;
		end
		if (c[2:1] == 2'h3 || (c[4] && c[3]) || (c[3] && c[2])) begin
			return boot_strap_pkg::BOOT_INT_UNDEF;
		end
		if (c[3]) begin
			return c[1] ? boot_strap_pkg::BOOT_EEPROM
				: boot_strap_pkg::BOOT_SERIAL_DL;
		end
		return c[4] ? boot_strap_pkg::BOOT_NAND16 : boot_strap_pkg::BOOT_NAND8;
	endfunction
	// Strap pattern that the board must never present
	function automatic logic bad(input logic [4:0] c);
		return !c[0] && !c[3] && c[2:1] == 2'h3;
	endfunction
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Verdict and end of run
	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One power-on boot with a given pattern
	task automatic boot(input logic [4:0] c);
		int n;
		logic ext, nand_ok;
		n = 0;
		ext = !c[0];
		nand_ok = c[0] && !c[3] && c[2:1] != 2'h3;
		@(posedge clk);
		rst_n <= 1'b0;
		pattern <= c;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		while (rel !== 1'b1 && n < 64) begin
			@(negedge clk);
			n++;
		end
		chk(8'(rel), 8'h01);
		chk(8'({valid, busy}), 8'h02);
		chk(8'({intb, undef}),
			8'({c[0], ex(c) == boot_strap_pkg::BOOT_INT_UNDEF}));
		chk(8'(src), 8'(ex(c)));
		chk(8'(bank), (ext && c[3]) ? 8'h04 : 8'h00);
		chk(8'({map3, map0}), 8'({ext && c[3], ext && !c[3]}));
		chk(8'(init), 8'(ext && c[3]));
		chk(8'(inval), 8'(ext && !c[3] && c[2:1] == 2'h3));
		if (nand_ok) begin
			chk(8'(nbytes), 8'(3'h3 + c[2:1]));
			chk(8'(bw), 8'(c[4]));
		end
		if (ext && c[3]) begin
			chk(8'(bw), 8'({c[2], !c[2]}));
		end
		if (ext && !c[3] && c[2:1] != 2'h3) begin
			chk(8'(bw), 8'(c[2:1]));
		end
		@(posedge clk);
		pattern <= bad(~c) ? ~c ^ 5'h02 : ~c;
		repeat (8) @(negedge clk);
		chk(8'(latched), 8'(c));
		chk(8'(src), 8'(ex(c)));
	endtask
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			close_out();
		end
	end
	// Every strap pattern in turn, except the two that the board must never present
	initial begin
		for (int i = 0; i < 32; i++) begin
			if (!bad(5'(i))) begin
				boot(5'(i));
			end
		end
		close_out();
	end
endmodule
